// ---- rtl/aus_bank.sv ----
/*
  Axis unit, filter and trigger source configuration bank with an APB
  slave, command-driven application of the filter type and the latch
  source, and a masked interrupt for setting errors and events.
  Assumes pclk at 100 MHz, presetn asynchronous active low, commands
  from the motion sequencer as one-cycle pulses synchronous to pclk.
*/
`timescale 1ns/100ps

module aus_bank #(
  parameter logic [3:0] SUPPORT_MASK = 4'hF  // sources the drive offers
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  input  wire logic         change_filter_type_command,
  input  wire logic         latch_command,
  input  wire logic         latch_done,
  input  wire logic         ext_pos_command,
  output logic [3:0]        applied_filter,
  output logic [3:0]        latch_select,
  output logic [3:0]        ext_pos_select,
  output logic              latch_busy,
  output logic [1:0]        speed_unit,
  output logic              accel_is_time,
  output logic              torque_fine,
  output logic              setting_error,
  output logic              irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0]                 units_q;
  logic [15:0]                 trig_q;
  logic [3:0]                  filt_q;
  logic [3:0]                  lat_sel_q;
  logic [3:0]                  pos_sel_q;
  logic                        busy_q;
  logic [aus_pkg::AUS_ST_W-1:0] status_q;
  logic [aus_pkg::AUS_ST_W-1:0] mask_q;
  logic [aus_pkg::AUS_ST_W-1:0] events;
  logic [aus_pkg::AUS_ST_W-1:0] status_d;
  logic [aus_pkg::AUS_ST_W-1:0] mask_d;
  logic                        irq_q;
  logic                        err_q;
  logic [31:0]                 rdata_d;
  logic                        hit;
  logic                        wr_acc;
  logic                        rd_acc;
  logic                        rd_status;
  logic                        setup_seen;

  // one-hot phases of the bus slave
  typedef enum logic [1:0] {
    AUS_BUS_IDLE = 2'b01,
    AUS_BUS_ACK  = 2'b10
  } aus_bus_type;
  aus_bus_type bus_q;

  aus_src_if lat_if ();
  aus_src_if pos_if ();

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte-enable merge of a 16-bit word, used by both setting words
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0]) r[7:0]  = wd[7:0];
    if (st[1]) r[15:8] = wd[15:8];
    return r;
  endfunction

  // extract a 4-bit field of a word
  function automatic logic [3:0] field(input logic [15:0] w,
                                       input int          lsb);
    return w[lsb +: aus_pkg::AUS_FW];
  endfunction

  // ---------------------------------------------------------------
  // source checkers on the written codes
  // ---------------------------------------------------------------
  assign lat_if.code    = field(trig_q, aus_pkg::AUS_LAT_LSB);
  assign lat_if.support = SUPPORT_MASK;
  assign pos_if.code    = field(trig_q, aus_pkg::AUS_POS_LSB);
  assign pos_if.support = SUPPORT_MASK;

  aus_src_check u_lat_chk (.sif(lat_if.check));
  aus_src_check u_pos_chk (.sif(pos_if.check));

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // no wait state: the answer comes in the first access cycle
  assign wr_acc = (bus_q == AUS_BUS_ACK) && psel && penable && pwrite;
  assign rd_acc = (bus_q == AUS_BUS_ACK) && psel && penable && !pwrite;
  assign rd_status = rd_acc && (paddr == aus_pkg::AUS_OFF_STATUS);
  // setup seen while idle; the answer follows in the next cycle
  assign setup_seen = (bus_q == AUS_BUS_IDLE) && psel && !penable;

  always_comb begin
    hit = 1'b1;
    case (paddr)
      aus_pkg::AUS_OFF_UNITS,
      aus_pkg::AUS_OFF_TRIG,
      aus_pkg::AUS_OFF_APPLIED,
      aus_pkg::AUS_OFF_STATUS,
      aus_pkg::AUS_OFF_MASK,
      aus_pkg::AUS_OFF_LATCHED: hit = 1'b1;
      default:                  hit = 1'b0;
    endcase
  end

  // read multiplexer; unused upper bits read as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      aus_pkg::AUS_OFF_UNITS:   rdata_d = {16'h0000, units_q};
      aus_pkg::AUS_OFF_TRIG:    rdata_d = {16'h0000, trig_q};
      aus_pkg::AUS_OFF_APPLIED: rdata_d = {28'h000_0000, filt_q};
      aus_pkg::AUS_OFF_STATUS:  rdata_d = {28'h000_0000, status_q};
      aus_pkg::AUS_OFF_MASK:    rdata_d = {28'h000_0000, mask_q};
      aus_pkg::AUS_OFF_LATCHED: rdata_d = {23'h00_0000, busy_q,
                                           pos_sel_q, lat_sel_q};
      default:                  rdata_d = 32'h0000_0000;
    endcase
  end

  // bus phase: setup seen -> answer next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_q <= AUS_BUS_IDLE;
    end else begin
      case (bus_q)
        AUS_BUS_IDLE: if (psel && !penable) bus_q <= AUS_BUS_ACK;
        AUS_BUS_ACK:  bus_q <= AUS_BUS_IDLE;
        default:      bus_q <= AUS_BUS_IDLE;
      endcase
    end
  end

  // bus outputs registered so every port comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_seen;
      pslverr <= setup_seen && !hit;
      if (setup_seen && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // setting words
  // ---------------------------------------------------------------
  // writes take effect at the edge that samples pready high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      units_q <= aus_pkg::AUS_UNITS_RST;
      trig_q  <= aus_pkg::AUS_TRIG_RST;
    end else if (wr_acc && pready) begin
      case (paddr)
        aus_pkg::AUS_OFF_UNITS: units_q <= merge16(units_q, pwdata, pstrb);
        aus_pkg::AUS_OFF_TRIG:  trig_q  <= merge16(trig_q, pwdata, pstrb);
        default: ;
      endcase
    end
  end

  // mask next value, shared with the interrupt so that the line
  // follows a mask write at once instead of a cycle late
  always_comb begin
    mask_d = mask_q;
    if (wr_acc && pready && pstrb[0]
        && (paddr == aus_pkg::AUS_OFF_MASK)) begin
      mask_d = pwdata[aus_pkg::AUS_ST_W-1:0];
    end
  end

  // interrupt mask, cleared at reset so no line rises unasked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '0;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ---------------------------------------------------------------
  // unit selections, live from the written word
  // ---------------------------------------------------------------
  // the command side reads these when it runs a move; the codes are
  // decoded from the word, and unknown codes fall back to the reset default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_unit    <= aus_pkg::AUS_SPD_POW10_MIN[1:0];
      accel_is_time <= 1'b1;
      torque_fine   <= 1'b0;
    end else begin
      case (field(units_q, aus_pkg::AUS_SPEED_LSB))
        aus_pkg::AUS_SPD_REF_PER_S: speed_unit <= aus_pkg::AUS_UNIT_A;
        aus_pkg::AUS_SPD_POW10_MIN: speed_unit <= aus_pkg::AUS_UNIT_B;
        aus_pkg::AUS_SPD_PCT_HUND:  speed_unit <= aus_pkg::AUS_UNIT_C;
        aus_pkg::AUS_SPD_PCT_TTHOU: speed_unit <= aus_pkg::AUS_UNIT_D;
        default:                    speed_unit <= aus_pkg::AUS_UNIT_B;
      endcase
      accel_is_time <= field(units_q, aus_pkg::AUS_ACC_LSB)
                       != aus_pkg::AUS_ACC_RATE;
      torque_fine   <= field(units_q, aus_pkg::AUS_TORQ_LSB)
                       == aus_pkg::AUS_TRQ_PCT_TTHOU;
    end
  end

  // ---------------------------------------------------------------
  // applied filter type
  // ---------------------------------------------------------------
  // held until the change command; unknown codes leave it as it was
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q <= aus_pkg::AUS_FILT_RST;
    end else if (change_filter_type_command) begin
      case (field(units_q, aus_pkg::AUS_FILT_LSB))
        aus_pkg::AUS_FILT_NONE,
        aus_pkg::AUS_FILT_EXP,
        aus_pkg::AUS_FILT_AVG: filt_q <= field(units_q,
                                               aus_pkg::AUS_FILT_LSB);
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // trigger source sampling
  // ---------------------------------------------------------------
  // latch source frozen at command; new commands ignored while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_sel_q <= aus_pkg::AUS_SRC_RST;
      busy_q    <= 1'b0;
    end else if (latch_command && !busy_q) begin
      lat_sel_q <= lat_if.code;
      busy_q    <= lat_if.valid;
    end else if (latch_done) begin
      busy_q    <= 1'b0;
    end
  end

  // positioning source sampled when that command runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_sel_q <= aus_pkg::AUS_SRC_RST;
    end else if (ext_pos_command) begin
      pos_sel_q <= pos_if.code;
    end
  end

  // ---------------------------------------------------------------
  // warnings and interrupt
  // ---------------------------------------------------------------
  // warning level follows the present codes, so fixing the word clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else begin
      err_q <= !lat_if.valid || !pos_if.valid;
    end
  end

  // events: bad source used by a command, filter command given, latch armed
  always_comb begin
    events = '0;
    events[aus_pkg::AUS_ST_LAT_ERR] = latch_command && !busy_q
                                      && !lat_if.valid;
    events[aus_pkg::AUS_ST_POS_ERR] = ext_pos_command
                                      && !pos_if.valid;
    events[aus_pkg::AUS_ST_FILT]    = change_filter_type_command;
    events[aus_pkg::AUS_ST_LATCH]   = latch_command && !busy_q
                                      && lat_if.valid;
  end

  // sticky status cleared by reading it; a new event wins the clear
  always_comb begin
    status_d = status_q | events;
    if (rd_status && pready) begin
      status_d = events;
    end
  end

  // status register; bits stay until software reads them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // level line from next status and mask, so it drops with the read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_d);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign applied_filter = filt_q;
  assign latch_select   = lat_sel_q;
  assign ext_pos_select = pos_sel_q;
  assign latch_busy     = busy_q;
  assign setting_error  = err_q;
  assign irq            = irq_q;

endmodule // aus_bank

// ---- rtl/aus_pkg.sv ----
/*
  Package for the axis unit and trigger configuration bank: register
  offsets, field positions, reset values, codes and status bit layout.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package aus_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] AUS_OFF_UNITS   = 8'h00;
  localparam logic [7:0] AUS_OFF_TRIG    = 8'h04;
  localparam logic [7:0] AUS_OFF_APPLIED = 8'h08;
  localparam logic [7:0] AUS_OFF_STATUS  = 8'h0C;
  localparam logic [7:0] AUS_OFF_MASK    = 8'h10;
  localparam logic [7:0] AUS_OFF_LATCHED = 8'h14;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] AUS_UNITS_RST = 16'h0011;
  localparam logic [15:0] AUS_TRIG_RST  = 16'h0033;
  localparam logic [3:0]  AUS_FILT_RST  = 4'h0;
  localparam logic [3:0]  AUS_SRC_RST   = 4'h3;

  // ---------------------------------------------------------------
  // field positions, all fields four bits wide
  // ---------------------------------------------------------------
  localparam int AUS_FW        = 4;
  localparam int AUS_SPEED_LSB = 0;
  localparam int AUS_ACC_LSB   = 4;
  localparam int AUS_FILT_LSB  = 8;
  localparam int AUS_TORQ_LSB  = 12;
  localparam int AUS_LAT_LSB   = 0;
  localparam int AUS_POS_LSB   = 4;

  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [3:0] AUS_SPD_REF_PER_S   = 4'h0;
  localparam logic [3:0] AUS_SPD_POW10_MIN   = 4'h1;
  localparam logic [3:0] AUS_SPD_PCT_HUND    = 4'h2;
  localparam logic [3:0] AUS_SPD_PCT_TTHOU   = 4'h3;
  localparam logic [3:0] AUS_ACC_RATE        = 4'h0;
  localparam logic [3:0] AUS_ACC_TIME_MS     = 4'h1;
  localparam logic [3:0] AUS_FILT_NONE       = 4'h0;
  localparam logic [3:0] AUS_FILT_EXP        = 4'h1;
  localparam logic [3:0] AUS_FILT_AVG        = 4'h2;
  localparam logic [3:0] AUS_TRQ_PCT_HUND    = 4'h0;
  localparam logic [3:0] AUS_TRQ_PCT_TTHOU   = 4'h1;
  localparam logic [3:0] AUS_SRC_PHASE_C     = 4'h2;
  localparam logic [3:0] AUS_SRC_EXT_ONE     = 4'h3;
  localparam logic [3:0] AUS_SRC_EXT_TWO     = 4'h4;
  localparam logic [3:0] AUS_SRC_EXT_THREE   = 4'h5;

  // ---------------------------------------------------------------
  // status / mask bit positions
  // ---------------------------------------------------------------
  localparam int AUS_ST_W       = 4;
  localparam int AUS_ST_LAT_ERR = 0;
  localparam int AUS_ST_POS_ERR = 1;
  localparam int AUS_ST_FILT    = 2;
  localparam int AUS_ST_LATCH   = 3;

  // decoded unit selections handed to the command side
  typedef enum logic [1:0] {
    AUS_UNIT_A = 2'h0,
    AUS_UNIT_B = 2'h1,
    AUS_UNIT_C = 2'h2,
    AUS_UNIT_D = 2'h3
  } aus_unit_type;

endpackage : aus_pkg

// ---- rtl/aus_src_check.sv ----
/*
  Trigger source checker: decodes a source code to a one-hot select and
  judges whether it is assigned and supported by the attached drive.
  Assumes a purely combinational use inside the pclk domain.
*/
`timescale 1ns/100ps
module aus_src_check (
  aus_src_if.check sif
);

  // ---------------------------------------------------------------
  // decode and validity
  // ---------------------------------------------------------------
  // codes 0, 1 and above 5 are unassigned, hence invalid
  always_comb begin
    sif.onehot = 4'h0;
    case (sif.code)
      aus_pkg::AUS_SRC_PHASE_C:   sif.onehot = 4'h1;
      aus_pkg::AUS_SRC_EXT_ONE:   sif.onehot = 4'h2;
      aus_pkg::AUS_SRC_EXT_TWO:   sif.onehot = 4'h4;
      aus_pkg::AUS_SRC_EXT_THREE: sif.onehot = 4'h8;
      default:                    sif.onehot = 4'h0;
    endcase
  end

  // valid only if the drive offers the chosen input
  assign sif.valid = |(sif.onehot & sif.support);

endmodule // aus_src_check

// ---- rtl/aus_src_if.sv ----
/*
  Interface carrying a trigger source code to the checker and its
  verdict back. Assumes both ends sit in the pclk domain.
*/
`timescale 1ns/100ps
interface aus_src_if;
  logic [3:0] code;
  logic [3:0] support;   // drives' supported-source flags
  logic       valid;     // code assigned and supported
  logic [3:0] onehot;    // phase c, ext one, ext two, ext three

  modport owner (output code, output support, input valid, input onehot);
  modport check (input code, input support, output valid, output onehot);
endinterface : aus_src_if

// ---- tb/aus_bank_props.sv ----
/*
  Checker for the configuration bank, watching top-level ports only.
  Assumes one pclk domain with presetn asynchronous and active low.
*/
`timescale 1ns/100ps
module aus_bank_props #(
  parameter logic [3:0] SUPPORT_MASK = 4'hF
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       change_filter_type_command,
  input wire logic       latch_command,
  input wire logic       latch_done,
  input wire logic       ext_pos_command,
  input wire logic [3:0] applied_filter,
  input wire logic [3:0] latch_select,
  input wire logic [3:0] ext_pos_select,
  input wire logic       latch_busy,
  input wire logic       irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // apb answer comes in the access cycle and lasts one cycle
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdy_one;
    pready |=> !pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready too long");

  // applied filter moves only on its command, never to a bad code
  property p_filt_hold;
    !change_filter_type_command |=> $stable(applied_filter);
  endproperty
  a_filt_hold: assert property (p_filt_hold)
    else $error("filter changed without command");
  property p_filt_code;
    applied_filter <= 4'h2;
  endproperty
  a_filt_code: assert property (p_filt_code)
    else $error("applied filter code out of range");

  // selections are sampled only by their commands
  property p_lat_hold;
    !latch_command |=> $stable(latch_select);
  endproperty
  a_lat_hold: assert property (p_lat_hold)
    else $error("latch select moved without command");
  property p_pos_hold;
    !ext_pos_command |=> $stable(ext_pos_select);
  endproperty
  a_pos_hold: assert property (p_pos_hold)
    else $error("positioning select moved without command");

  // an armed latch holds its source until the drive reports done
  property p_busy_keep;
    latch_busy && !latch_done |=> latch_busy && $stable(latch_select);
  endproperty
  a_busy_keep: assert property (p_busy_keep)
    else $error("latch in progress disturbed");
  property p_done;
    latch_busy && latch_done |=> !latch_busy;
  endproperty
  a_done: assert property (p_done)
    else $error("latch not ended by done");

  // arming only follows a command with an assigned, supported source
  property p_arm_ok;
    $rose(latch_busy) |-> $past(latch_command) &&
      latch_select inside {[4'h2:4'h5]} &&
      SUPPORT_MASK[latch_select[1:0] - 2'h2];
  endproperty
  a_arm_ok: assert property (p_arm_ok)
    else $error("latch armed with bad source");

  c_filt: cover property (change_filter_type_command ##1
                          applied_filter == 4'h2);
  c_arm: cover property ($rose(latch_busy));
  c_irq: cover property ($fell(irq));
endmodule // aus_bank_props

bind aus_bank aus_bank_props #(.SUPPORT_MASK(SUPPORT_MASK)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .change_filter_type_command(change_filter_type_command),
  .latch_command(latch_command), .latch_done(latch_done),
  .ext_pos_command(ext_pos_command), .applied_filter(applied_filter),
  .latch_select(latch_select), .ext_pos_select(ext_pos_select),
  .latch_busy(latch_busy), .irq(irq)
);

// ---- tb/aus_drv_model.sv ----
/*
  Drive model: reports the latch event a while after a latch is armed.
  Assumes latch_busy from the bank, pclk domain, slow picks the delay.
*/
`timescale 1ns/100ps
module aus_drv_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic latch_busy,
  input wire logic slow,
  output logic     latch_done
);
  logic [5:0] cnt_q;

  // one-cycle done pulse; slow leaves room to disturb a running latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= 6'h00;
      latch_done <= 1'b0;
    end else if (!latch_busy) begin
      cnt_q      <= 6'h00;
      latch_done <= 1'b0;
    end else begin
      cnt_q      <= cnt_q + 6'h01;
      latch_done <= (cnt_q == (slow ? 6'h1E : 6'h01));
    end
  end
endmodule // aus_drv_model

// ---- tb/tb_aus_bank.sv ----
/*
  Testbench for the configuration bank: apb master, command pulses and
  a drive model. Assumes the bank answers apb after one access cycle.
*/
`timescale 1ns/100ps
module tb_aus_bank;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, applied_filter, latch_select, ext_pos_select;
  logic        cmd_filt, cmd_lat, cmd_pos, latch_done, latch_busy, er;
  logic        accel_is_time, torque_fine, setting_error, irq, slow;
  logic [1:0]  speed_unit;
  int          fails, checks;

  // only phase c and input one offered, so inputs two and three are bad
  aus_bank #(.SUPPORT_MASK(4'h3)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .change_filter_type_command(cmd_filt), .latch_command(cmd_lat),
    .latch_done(latch_done), .ext_pos_command(cmd_pos),
    .applied_filter(applied_filter), .latch_select(latch_select),
    .ext_pos_select(ext_pos_select), .latch_busy(latch_busy),
    .speed_unit(speed_unit), .accel_is_time(accel_is_time),
    .torque_fine(torque_fine), .setting_error(setting_error), .irq(irq));
  aus_drv_model u_drv (.pclk(pclk), .presetn(presetn),
    .latch_busy(latch_busy), .slow(slow), .latch_done(latch_done));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [2:0] v);
    @(posedge pclk);
    {cmd_pos, cmd_lat, cmd_filt} <= v;
    @(posedge pclk);
    {cmd_pos, cmd_lat, cmd_filt} <= 3'h0;
    #1;
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", fails, checks);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic t_reset;
    chk(32'(speed_unit), 32'h1);
    chk(32'(accel_is_time), 32'h1);
    chk(32'(torque_fine), 32'h0);
    chk(32'(applied_filter), 32'h0);
    chk(32'({latch_select, ext_pos_select}), 32'h33);
    apb(1'b0, aus_pkg::AUS_OFF_UNITS, 32'h0);
    chk(rd, 32'h0011);
    apb(1'b0, aus_pkg::AUS_OFF_TRIG, 32'h0);
    chk(rd, 32'h0033);
    apb(1'b0, 8'h18, 32'h0);
    chk({rd[30:0], er}, 32'h1);
  endtask

  task automatic t_units;
    logic [31:0] w;
    for (int i = 0; i < 4; i++) begin
      w = {16'h0, 4'(i % 2), 4'h0, 4'(i / 2), 4'(i)};
      apb(1'b1, aus_pkg::AUS_OFF_UNITS, w);
      tick(1);
      chk(32'(speed_unit), 32'(i));
      chk(32'(accel_is_time), 32'(i / 2));
      chk(32'(torque_fine), 32'(i % 2));
      apb(1'b0, aus_pkg::AUS_OFF_UNITS, 32'h0);
      chk(rd, w);
    end
    // an unassigned speed code falls back to the default unit
    apb(1'b1, aus_pkg::AUS_OFF_UNITS, 32'h0004);
    tick(1);
    chk(32'(speed_unit), 32'h1);
  endtask

  // code 3 is refused, so the previous filter stays
  task automatic t_filter;
    logic [3:0] tab [4] = '{4'h2, 4'h1, 4'h3, 4'h0};
    logic [3:0] want [4] = '{4'h2, 4'h1, 4'h1, 4'h0};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, aus_pkg::AUS_OFF_UNITS, {20'h0, tab[i], 8'h11});
      tick(1);
      chk(32'(applied_filter), 32'(want[(i + 3) % 4]));
      cmd(3'b001);
      chk(32'(applied_filter), 32'(want[i]));
    end
    apb(1'b0, aus_pkg::AUS_OFF_APPLIED, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, aus_pkg::AUS_OFF_STATUS, 32'h0);
    chk(rd, 32'h4);
  endtask

  // both sources get the same code; irq masked on the first pass
  task automatic t_trig;
    logic good;
    for (int c = 0; c < 7; c++) begin
      good = (c == 2 || c == 3);
      apb(1'b1, aus_pkg::AUS_OFF_TRIG, 32'(c * 17));
      tick(1);
      chk(32'(setting_error), 32'(!good));
      apb(1'b0, aus_pkg::AUS_OFF_STATUS, 32'h0);
      slow <= (c == 2);
      cmd(3'b110);
      chk(32'(latch_select), 32'(c));
      chk(32'(ext_pos_select), 32'(c));
      chk(32'(latch_busy), 32'(good));
      if (c == 0) begin
        chk(32'(irq), 32'h0);
        apb(1'b1, aus_pkg::AUS_OFF_MASK, 32'hF);
        apb(1'b0, aus_pkg::AUS_OFF_MASK, 32'h0);
        chk(rd, 32'hF);
        tick(1);
      end
      chk(32'(irq), 32'h1);
      apb(1'b0, aus_pkg::AUS_OFF_STATUS, 32'h0);
      chk(rd, good ? 32'h8 : 32'h3);
      tick(1);
      chk(32'(irq), 32'h0);
      if (c == 2) begin
        apb(1'b1, aus_pkg::AUS_OFF_TRIG, 32'h35);
        cmd(3'b010);
        chk(32'(latch_select), 32'h2);
        apb(1'b0, aus_pkg::AUS_OFF_LATCHED, 32'h0);
        chk(rd, 32'h122);
      end
      for (int n = 0; n < 60 && latch_busy; n++) tick(1);
      chk(32'(latch_busy), 32'h0);
    end
  endtask

  initial begin
    {psel, penable, pwrite, cmd_filt, cmd_lat, cmd_pos, slow} = 7'h00;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'hF;
    fails   = 0;
    checks  = 0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    tick(1);
    t_reset;
    t_units;
    t_filter;
    t_trig;
    report_and_stop;
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    report_and_stop;
  end
endmodule // tb_aus_bank
